// >>> sim/cam_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module cam_master_model
#(
    parameter int FRAME_LINES = 625
)
(
    input wire logic i_mclk,
    input wire logic i_slave,
    input wire logic i_go,
    output logic o_line_sync,
    output logic o_frame_sync,
    output logic o_request
);
    int pix = 0;
    int line = 0;
    int hold = 0;
    always @(posedge i_mclk)
    begin
        pix <= (pix == 471) ? 0 : pix + 1;
        if (pix == 471)
            line <= (line == FRAME_LINES - 1) ? 0 : line + 1;
        // request outlasts precharge plus a line of uncertainty
        if (i_go)
            hold <= 1168 + 472 + 200;
        else if (hold > 0)
            hold <= hold - 1;
    end
    assign o_line_sync = i_slave && pix < 8;
    assign o_frame_sync = i_slave && line == 0 && pix < 16;
    assign o_request = hold > 0;
endmodule
`default_nettype wire

// >>> sim/camera_reset_power_exposure_ctrl_chk.sv
`timescale 1ns/1ns
`default_nettype none
module camera_reset_power_exposure_ctrl_chk
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_reset_pin,
    input wire logic i_standby_request_pin,
    input wire logic i_frame_exposure_request,
    input wire logic o_line_sync_oe,
    input wire logic o_line_valid,
    input wire logic o_data_valid,
    input wire logic o_busy,
    input wire logic o_standby,
    input wire logic o_pix_en
);
    // line starts since the request last fell, saturating
    logic [3:0] lines;
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
            lines <= 4'hf;
        else if ($fell(i_frame_exposure_request))
            lines <= 4'h0;
        else if (o_line_valid && lines != 4'hf)
            lines <= lines + 4'h1;
    end
    // cycles since the reset pin fell while the strap phase runs
    logic [10:0] strap_age;
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
            strap_age <= 11'h000;
        else if ($fell(i_reset_pin))
            strap_age <= 11'h001;
        else if (!o_busy)
            strap_age <= 11'h000;
        else if (strap_age != 11'h000 && strap_age != 11'h7ff)
            strap_age <= strap_age + 11'h001;
    end
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);
    chk_dummy_lines_blank:
        assert property (o_line_valid && lines < 4'h8 |-> !o_data_valid)
        else $error("data valid during a dummy line");
    chk_first_valid_line:
        assert property (o_line_valid && lines == 4'h8 |-> o_data_valid)
        else $error("ninth line after request is not valid");
    chk_stream_after_fall:
        assert property (o_line_valid |-> !$past(i_frame_exposure_request, 2))
        else $error("line output while request high");
    chk_standby_quiet:
        assert property (o_standby && $past(o_standby)
            |-> !o_pix_en && !o_busy)
        else $error("activity during standby");
    chk_standby_synced:
        assert property ($rose(i_standby_request_pin) |-> ##[1:3] o_standby)
        else $error("standby not taken");
    chk_pin_reset_master:
        assert property ($rose(i_reset_pin) |-> ##[2:4] o_line_sync_oe)
        else $error("pin reset did not restore master mode");
    chk_strap_busy_held:
        assert property ($fell(i_reset_pin) |-> ##4 o_busy [*8])
        else $error("strap phase not busy");
    chk_strap_done:
        assert property (strap_age <= 11'h406)
        else $error("strap phase too long");
    chk_request_starts:
        assert property ($rose(i_frame_exposure_request) && !o_busy
            && !o_standby |-> ##[1:4] o_busy)
        else $error("exposure request ignored");
endmodule
`default_nettype wire

// >>> sim/camera_reset_power_exposure_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none
module camera_reset_power_exposure_ctrl_test;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic rpin = 1'b0;
    logic sby = 1'b0;
    logic we = 1'b0;
    logic slv = 1'b0;
    logic go = 1'b0;
    logic [7:0] strap = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [2:0] addr = 3'h0;
    logic [7:0] rdata;
    logic lso, lsoe, fso, fsoe, pix, lv, dv, busy, stbl, sbo, pd;
    logic mls, mfs, req;
    int err_total = 0;
    int comparisons = 0;
    wire logic lsw = lsoe ? lso : mls;
    wire logic fsw = fsoe ? fso : mfs;
    initial
    begin
        forever #5 mclk = ~mclk;
    end
    camera_reset_power_exposure_ctrl uut
    (
        .i_mclk(mclk), .i_rstn(rstn), .i_reset_pin(rpin),
        .i_standby_request_pin(sby), .i_frame_exposure_request(req),
        .i_line_sync_pin(lsw), .i_frame_sync_pin(fsw), .i_strap(strap),
        .i_reg_we(we), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_line_sync_out(lso), .o_line_sync_oe(lsoe),
        .o_frame_sync_out(fso), .o_frame_sync_oe(fsoe), .o_pix_en(pix),
        .o_line_valid(lv), .o_data_valid(dv), .o_busy(busy),
        .o_stable(stbl), .o_standby(sbo), .o_powered_down(pd)
    );
    // frames shortened to four lines to keep the run brief
    cam_master_model #(.FRAME_LINES(4)) partner
    (
        .i_mclk(mclk), .i_slave(slv), .i_go(go),
        .o_line_sync(mls), .o_frame_sync(mfs), .o_request(req)
    );
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        we = 1'b1;
        tick(1);
        we = 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        addr = a;
        tick(2);
        chk(rdata, e);
    endtask
    task automatic wait_busy(input logic lvl, output int n);
        n = 0;
        while (busy !== lvl)
        begin
            tick(1);
            n++;
            if (n > 5000)
            begin
                err_total++;
                wrap_up();
            end
        end
    endtask
    task automatic t_regs();
        int n;
        n = 0;
        rd(cam_ctrl_pkg::REG_CTRL_A, cam_ctrl_pkg::CTRL_RESET);
        rd(cam_ctrl_pkg::REG_CLKDIV, {2'b00, cam_ctrl_pkg::DIV_RESET});
        wait_busy(1'b0, n);
        chk(8'(n <= 1024), 8'h01);
        n = 0;
        wr(3'h3, 8'ha5);
        wr(3'h7, 8'h3c);
        rd(3'h3, 8'ha5);
        rd(3'h7, 8'h3c);
        wr(cam_ctrl_pkg::REG_CLKDIV, 8'h03);
        for (int i = 0; i < 40; i++)
        begin
            n = n + int'(pix);
            tick(1);
        end
        chk(8'(n), 8'h0a);
        wr(cam_ctrl_pkg::REG_CLKDIV, 8'h00);
        // the divider may wrap once before enables run every cycle
        tick(64);
        n = 0;
        for (int i = 0; i < int'(cam_ctrl_pkg::LINE_PIX); i++)
        begin
            n = n + int'(lso);
            tick(1);
        end
        chk(8'(n), 8'(cam_ctrl_pkg::LSYNC_PIX));
    endtask
    task automatic t_pin_reset();
        int n;
        strap = 8'h1a;
        rpin = 1'b1;
        tick(3);
        rpin = 1'b0;
        tick(3);
        chk({7'h00, busy}, 8'h01);
        wr(3'h4, 8'h77);
        wait_busy(1'b0, n);
        chk(8'(n <= 1024), 8'h01);
        rd(cam_ctrl_pkg::REG_CTRL_A, 8'h1a);
        rd(3'h3, 8'h00);
        rd(3'h4, 8'h00);
        strap = 8'h00;
        wr(cam_ctrl_pkg::REG_CTRL_A, 8'h00);
    endtask
    task automatic t_soft();
        wr(3'h5, 8'h99);
        wr(cam_ctrl_pkg::REG_CMD, 8'h01 << cam_ctrl_pkg::CMD_SOFT_RESET);
        tick(3);
        rd(3'h5, 8'h00);
        wr(cam_ctrl_pkg::REG_CMD, 8'h01 << cam_ctrl_pkg::CMD_SOFT_PD);
        tick(2);
        chk({6'h00, pd, sbo}, 8'h02);
        wr(cam_ctrl_pkg::REG_CMD, 8'h00);
    endtask
    task automatic t_standby();
        wr(3'h6, 8'h42);
        sby = 1'b1;
        tick(4);
        chk({5'h00, sbo, pix, busy}, 8'h04);
        sby = 1'b0;
        tick(4);
        rd(3'h6, 8'h00);
    endtask
    task automatic t_slave();
        int n;
        n = 0;
        slv = 1'b1;
        wr(cam_ctrl_pkg::REG_CTRL_A, 8'h01 << cam_ctrl_pkg::CTRL_SLAVE_BIT);
        chk({5'h00, lsoe, fsoe, stbl}, 8'h00);
        while (stbl !== 1'b1 && n < 4000)
        begin
            tick(1);
            n++;
        end
        chk(8'(n > 1800 && n < 3900), 8'h01);
        // a pin reset must bring the sync pins back as outputs
        rpin = 1'b1;
        tick(4);
        rpin = 1'b0;
        slv = 1'b0;
        chk({6'h00, lsoe, fsoe}, 8'h03);
        wait_busy(1'b0, n);
    endtask
    task automatic t_expose();
        int n;
        int k;
        k = 0;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        wait_busy(1'b1, n);
        tick(1800);
        for (int i = 0; i < 5000 && k < 9; i++)
        begin
            if (lv === 1'b1)
            begin
                chk({7'h00, dv}, {7'h00, k == 8});
                k++;
            end
            tick(1);
        end
        chk(8'(k), 8'h09);
        sby = 1'b1;
        tick(4);
        chk({7'h00, busy}, 8'h00);
        sby = 1'b0;
        tick(4);
    endtask
    initial
    begin
        tick(20);
        rstn = 1'b1;
        tick(2);
        t_regs();
        t_pin_reset();
        t_soft();
        t_standby();
        t_slave();
        t_expose();
        wrap_up();
    end
endmodule
bind camera_reset_power_exposure_ctrl camera_reset_power_exposure_ctrl_chk chk_i
(
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_reset_pin(i_reset_pin),
    .i_standby_request_pin(i_standby_request_pin),
    .i_frame_exposure_request(i_frame_exposure_request),
    .o_line_sync_oe(o_line_sync_oe), .o_line_valid(o_line_valid),
    .o_data_valid(o_data_valid), .o_busy(o_busy),
    .o_standby(o_standby), .o_pix_en(o_pix_en)
);
`default_nettype wire

// >>> src/cam_ctrl_pkg.sv
package cam_ctrl_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned STRAP_TIME_CYC = 1024;
    localparam logic [10:0] STRAP_CYC = 11'(STRAP_TIME_CYC);
    localparam logic [10:0] STRAP_SAMPLE_AT = 11'h004;
    localparam logic [11:0] PRECHARGE_PIX = 12'(292 * 4);
    localparam logic [8:0] LINE_PIX = 9'h1d8;
    localparam logic [9:0] FRAME_LINES = 10'h271;
    localparam logic [8:0] LSYNC_PIX = 9'h010;
    localparam logic [8:0] FSYNC_PIX = 9'h040;
    localparam logic [3:0] DUMMY_LINES = 4'h8;
    localparam int unsigned CTRL_SLAVE_BIT = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [5:0] DIV_RESET = 6'h00;
    localparam int unsigned NREG = 8;
    localparam logic [2:0] REG_CTRL_A = 3'h0;
    localparam logic [2:0] REG_CLKDIV = 3'h1;
    localparam logic [2:0] REG_CMD = 3'h2;
    localparam int unsigned CMD_SOFT_RESET = 7;
    localparam int unsigned CMD_SOFT_PD = 4;
    typedef enum logic [2:0] {
        ST_STRAP, ST_IDLE, ST_SYNC_WAIT, ST_PRECHARGE, ST_EXPOSE,
        ST_DUMMY, ST_STREAM
    } seq_state_t;
endpackage

// >>> src/cam_regfile.sv
`timescale 1ns/1ns
`default_nettype none
module cam_regfile
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_srst,
    cam_regs_if.regs rif
);
    typedef struct packed {
        logic [cam_ctrl_pkg::NREG-1:0][7:0] mem;
        logic [7:0] rdata;
    } rf_state_t;
    rf_state_t st;
    rf_state_t next_st;
    always_comb
    begin
        next_st = st;
        next_st.rdata = st.mem[rif.addr];
        if (i_srst)
        begin
            next_st.mem = '0;
        end
        else if (rif.load)
        begin
            next_st.mem[cam_ctrl_pkg::REG_CTRL_A] = rif.strap;
        end
        else if (rif.we)
        begin
            next_st.mem[rif.addr] = rif.wdata;
        end
    end
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
    assign rif.rdata = st.rdata;
    assign rif.ctrl_a = st.mem[cam_ctrl_pkg::REG_CTRL_A];
    assign rif.clkdiv = st.mem[cam_ctrl_pkg::REG_CLKDIV];
    assign rif.cmd = st.mem[cam_ctrl_pkg::REG_CMD];
endmodule
`default_nettype wire

// >>> src/cam_regs_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cam_regs_if;
    logic we;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic load;
    logic [7:0] strap;
    logic [7:0] ctrl_a;
    logic [7:0] clkdiv;
    logic [7:0] cmd;
    modport regs (input we, addr, wdata, load, strap,
        output rdata, ctrl_a, clkdiv, cmd);
    modport user (output we, addr, wdata, load, strap,
        input rdata, ctrl_a, clkdiv, cmd);
endinterface
`default_nettype wire

// >>> src/camera_reset_power_exposure_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module camera_reset_power_exposure_ctrl
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_reset_pin,
    input wire logic i_standby_request_pin,
    input wire logic i_frame_exposure_request,
    input wire logic i_line_sync_pin,
    input wire logic i_frame_sync_pin,
    input wire logic [7:0] i_strap,
    input wire logic i_reg_we,
    input wire logic [2:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_line_sync_out,
    output logic o_line_sync_oe,
    output logic o_frame_sync_out,
    output logic o_frame_sync_oe,
    output logic o_pix_en,
    output logic o_line_valid,
    output logic o_data_valid,
    output logic o_busy,
    output logic o_stable,
    output logic o_standby,
    output logic o_powered_down
);
    typedef struct packed {
        logic [1:0] rst_s;
        logic [1:0] sby_s;
        logic [1:0] frame_exposure_request_s;
        logic [1:0] ls_s;
        logic [1:0] fs_s;
        logic ls_d;
        logic fs_d;
        logic frame_exposure_request_d;
        logic [7:0] strap;
        cam_ctrl_pkg::seq_state_t seq;
        logic [10:0] strap_cnt;
        logic [5:0] div_cnt;
        logic [8:0] pix_cnt;
        logic [9:0] line_cnt;
        logic [11:0] pre_cnt;
        logic [3:0] dummy_cnt;
        logic [1:0] fsync_seen;
        logic ls_out;
        logic fs_out;
        logic lv;
        logic dv;
    } top_state_t;
    top_state_t st;
    top_state_t next_st;
    cam_regs_if rif();
    logic hold_rst;
    logic srst;
    logic slave;
    logic pd;
    logic pix_en;
    logic ls_rise;
    logic fs_rise;
    logic frame_exposure_request_rise;
    logic frame_exposure_request_fall;
    logic line_end;
    assign slave = rif.ctrl_a[cam_ctrl_pkg::CTRL_SLAVE_BIT];
    assign pd = rif.cmd[cam_ctrl_pkg::CMD_SOFT_PD];
    // pin reset, standby or serial reset command clear registers and counters
    assign hold_rst = st.rst_s[1] | st.sby_s[1];
    assign srst = hold_rst | rif.cmd[cam_ctrl_pkg::CMD_SOFT_RESET];
    assign pix_en = (st.div_cnt == rif.clkdiv[5:0]) && !hold_rst;
    assign ls_rise = st.ls_s[1] && !st.ls_d;
    assign fs_rise = st.fs_s[1] && !st.fs_d;
    assign frame_exposure_request_rise = st.frame_exposure_request_s[1] && !st.frame_exposure_request_d;
    assign frame_exposure_request_fall = !st.frame_exposure_request_s[1] && st.frame_exposure_request_d;
    assign line_end = slave ? ls_rise : (pix_en &&
        st.pix_cnt == cam_ctrl_pkg::LINE_PIX - 9'h001);
    assign rif.we = i_reg_we && st.seq != cam_ctrl_pkg::ST_STRAP;
    assign rif.addr = i_reg_addr;
    assign rif.wdata = i_reg_wdata;
    assign rif.strap = st.strap;
    assign rif.load = st.seq == cam_ctrl_pkg::ST_STRAP &&
        st.strap_cnt == cam_ctrl_pkg::STRAP_CYC - 11'h001;
    cam_regfile u_regs
    (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_srst(srst),
        .rif(rif)
    );
    always_comb
    begin
        next_st = st;
        next_st.rst_s = {st.rst_s[0], i_reset_pin};
        next_st.sby_s = {st.sby_s[0], i_standby_request_pin};
        next_st.frame_exposure_request_s = {st.frame_exposure_request_s[0], i_frame_exposure_request};
        next_st.ls_s = {st.ls_s[0], i_line_sync_pin};
        next_st.fs_s = {st.fs_s[0], i_frame_sync_pin};
        next_st.ls_d = st.ls_s[1];
        next_st.fs_d = st.fs_s[1];
        next_st.frame_exposure_request_d = st.frame_exposure_request_s[1];
        if (pix_en)
        begin
            next_st.div_cnt = 6'h00;
        end
        else
        begin
            next_st.div_cnt = st.div_cnt + 6'h01;
        end
        if (st.seq == cam_ctrl_pkg::ST_STRAP)
        begin
            next_st.strap_cnt = st.strap_cnt + 11'h001;
            if (st.strap_cnt == cam_ctrl_pkg::STRAP_SAMPLE_AT)
            begin
                next_st.strap = i_strap;
            end
            if (rif.load)
            begin
                next_st.seq = cam_ctrl_pkg::ST_IDLE;
            end
        end
        else if (!pd)
        begin
            // master timing: free-running pixel and line counters
            if (!slave && pix_en)
            begin
                if (line_end)
                begin
                    next_st.pix_cnt = 9'h000;
                end
                else
                begin
                    next_st.pix_cnt = st.pix_cnt + 9'h001;
                end
                next_st.ls_out = st.pix_cnt < cam_ctrl_pkg::LSYNC_PIX;
                next_st.fs_out = st.line_cnt == 10'h000 &&
                    st.pix_cnt < cam_ctrl_pkg::FSYNC_PIX;
            end
            if (line_end)
            begin
                if (st.line_cnt == cam_ctrl_pkg::FRAME_LINES - 10'h001)
                begin
                    next_st.line_cnt = 10'h000;
                end
                else
                begin
                    next_st.line_cnt = st.line_cnt + 10'h001;
                end
            end
            // slave mode counts frame sync rises until stable
            if (slave && fs_rise)
            begin
                next_st.line_cnt = 10'h000;
                if (st.fsync_seen != 2'h2)
                begin
                    next_st.fsync_seen = st.fsync_seen + 2'h1;
                end
            end
            next_st.lv = 1'b0;
            case (st.seq)
                cam_ctrl_pkg::ST_IDLE:
                begin
                    if (frame_exposure_request_rise || st.frame_exposure_request_s[1])
                    begin
                        next_st.seq = cam_ctrl_pkg::ST_SYNC_WAIT;
                    end
                end
                cam_ctrl_pkg::ST_SYNC_WAIT:
                begin
                    if (!st.frame_exposure_request_s[1])
                    begin
                        next_st.seq = cam_ctrl_pkg::ST_IDLE;
                    end
                    else if (line_end)
                    begin
                        next_st.seq = cam_ctrl_pkg::ST_PRECHARGE;
                        next_st.pre_cnt = 12'h000;
                    end
                end
                cam_ctrl_pkg::ST_PRECHARGE:
                begin
                    if (pix_en)
                    begin
                        next_st.pre_cnt = st.pre_cnt + 12'h001;
                        if (st.pre_cnt ==
                            cam_ctrl_pkg::PRECHARGE_PIX - 12'h001)
                        begin
                            next_st.seq = cam_ctrl_pkg::ST_EXPOSE;
                        end
                    end
                end
                cam_ctrl_pkg::ST_EXPOSE:
                begin
                    if (frame_exposure_request_fall || !st.frame_exposure_request_s[1])
                    begin
                        next_st.seq = cam_ctrl_pkg::ST_DUMMY;
                        next_st.dummy_cnt = 4'h0;
                    end
                end
                cam_ctrl_pkg::ST_DUMMY:
                begin
                    if (line_end)
                    begin
                        next_st.lv = 1'b1;
                        next_st.dummy_cnt = st.dummy_cnt + 4'h1;
                        if (st.dummy_cnt ==
                            cam_ctrl_pkg::DUMMY_LINES - 4'h1)
                        begin
                            next_st.seq = cam_ctrl_pkg::ST_STREAM;
                        end
                    end
                end
                cam_ctrl_pkg::ST_STREAM:
                begin
                    if (line_end)
                    begin
                        next_st.lv = 1'b1;
                        if (st.line_cnt ==
                            cam_ctrl_pkg::FRAME_LINES - 10'h001)
                        begin
                            next_st.seq = cam_ctrl_pkg::ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    next_st.seq = cam_ctrl_pkg::ST_IDLE;
                end
            endcase
            // the line that ends the dummy run is still a dummy line
            next_st.dv = st.seq == cam_ctrl_pkg::ST_STREAM &&
                next_st.lv;
        end
        if (!slave)
        begin
            next_st.fsync_seen = 2'h0;
        end
        if (srst && st.seq != cam_ctrl_pkg::ST_STRAP)
        begin
            // counters and sequence return to rest, syncs keep sampling
            next_st.pix_cnt = '0;
            next_st.line_cnt = '0;
            next_st.pre_cnt = '0;
            next_st.dummy_cnt = '0;
            next_st.div_cnt = '0;
            next_st.fsync_seen = '0;
            next_st.ls_out = 1'b0;
            next_st.fs_out = 1'b0;
            next_st.lv = 1'b0;
            next_st.dv = 1'b0;
            next_st.seq = cam_ctrl_pkg::ST_IDLE;
        end
        // a held reset pin keeps the strap phase at its start
        if (st.rst_s[1])
        begin
            next_st.seq = cam_ctrl_pkg::ST_STRAP;
            next_st.strap_cnt = '0;
        end
        if (st.sby_s[1] && st.seq == cam_ctrl_pkg::ST_STRAP)
        begin
            next_st.strap_cnt = '0;
        end
    end
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
    assign o_reg_rdata = rif.rdata;
    assign o_line_sync_out = st.ls_out;
    assign o_line_sync_oe = !slave;
    assign o_frame_sync_out = st.fs_out;
    assign o_frame_sync_oe = !slave;
    assign o_pix_en = pix_en && !pd;
    assign o_line_valid = st.lv;
    assign o_data_valid = st.dv;
    assign o_busy = st.seq != cam_ctrl_pkg::ST_IDLE;
    assign o_stable = !slave || st.fsync_seen == 2'h2;
    assign o_standby = st.sby_s[1];
    assign o_powered_down = pd;
endmodule
`default_nettype wire
